// ### design/lmhw_top.sv
// Host watchdog, relay and alarm indication, silence input and communication mode selection.
`timescale 1ns/1ps
// Function
// - Alarm LED steady for leak, blinking for open wire; power LED on when running.
// - Silence button press stops the audible alarm output.
// - Factory defaults: address 1, Modbus RTU, 9600, N81, zero response delay.
// - Host programs watchdog timeout and enables or disables the watchdog.
// - Enabled watchdog without keep-alive in time flags timeout, relay goes safe.
// - After timeout host relay control is ignored until clear command clears status.
// - With leak alarm enabled the relay follows the alarm, not the safe value.
// - An enabled alarm becoming active switches the relay on.
// - Init switch at power-up forces ASCII, address 0, 9600, N81, no checksum.
// - Protocol, checksum changes accepted only in init mode, baud and parity also under Modbus; apply next power-up, except protocol (set by switch).
// - Under Modbus, address, baud and parity changes accepted; apply next power-up.
module lmhw_top #(
  parameter int TICK_CYCLES_P = lmhw_pkg::TICK_CYCLES
) (
  // Clock, reset and clock enable
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // Wishbone classic slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Pins
  input wire lmhw_pkg::lmhw_switch_type i_switches,
  input wire logic [3:0] i_addr_select,
  input wire logic i_silence_button,
  input wire logic i_leak_detect,
  input wire logic i_open_detect,
  // Non-volatile configuration store
  input wire lmhw_pkg::lmhw_comm_cfg_type i_stored_cfg,
  input wire logic i_stored_valid,
  output lmhw_pkg::lmhw_comm_cfg_type o_cfg_pending,
  output logic o_cfg_save,
  // Indication, relay and interrupt
  output logic o_relay,
  output logic o_alarm_led,
  output logic o_power_led,
  output logic o_buzzer,
  output logic o_irq
);
  import lmhw_pkg::*;

  logic [1:0] rst_sync_q;
  logic rst_n_q;
  logic [10:0] pins_s;
  lmhw_switch_type sw_s;
  logic [3:0] addr_sel_s;
  logic silence_s;
  logic leak_s;
  logic open_s;
  logic silence_prev_q;
  logic leak_prev_q;
  logic open_prev_q;
  logic acc;
  logic wr;
  logic ack_q;
  logic [31:0] rd_q;
  logic [31:0] rd_d;
  logic [CTRL_W-1:0] ctrl_q;
  logic [15:0] timeout_q;
  logic [2:0] irq_stat_q;
  logic [2:0] irq_mask_q;
  logic keepalive;
  logic clear_cmd;
  lmhw_wdt_state_type wdt_q;
  logic [31:0] tick_cnt_q;
  logic tick;
  logic [15:0] ms_cnt_q;
  logic expire;
  logic tripped;
  logic relay_d;
  logic relay_q;
  logic alarm_led_q;
  logic [15:0] blink_cnt_q;
  logic blink_q;
  logic silenced_q;
  logic [1:0] settle_q;
  logic cfg_loaded_q;
  logic init_mode_q;
  lmhw_comm_cfg_type active_q;
  lmhw_comm_cfg_type pending_q;
  lmhw_comm_cfg_type load_cfg;
  lmhw_comm_cfg_type wr_cfg;
  lmhw_comm_cfg_type merged_cfg;
  logic save_q;
  logic [31:0] timeout_mrg;
  logic [31:0] pend_mrg;

  // Reset is asserted at once and released through two flops.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n_q = rst_sync_q[1];

  lmhw_sync #(.WIDTH(11)) u_pin_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(rst_n_q),
    .i_clk_en(i_clk_en),
    .i_async({i_addr_select, i_switches, i_silence_button, i_leak_detect, i_open_detect}),
    .o_sync(pins_s)
  );
  assign addr_sel_s = pins_s[10:7];
  assign sw_s = pins_s[6:3];
  assign silence_s = pins_s[2];
  assign leak_s = pins_s[1];
  assign open_s = pins_s[0];

  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      silence_prev_q <= 1'b0;
      leak_prev_q <= 1'b0;
      open_prev_q <= 1'b0;
    end else if (i_clk_en) begin
      silence_prev_q <= silence_s;
      leak_prev_q <= leak_s;
      open_prev_q <= open_s;
    end
  end

  // Wishbone slave: each access is acknowledged one cycle after it is seen.
  assign acc = i_wb_cyc & i_wb_stb & ~ack_q;
  assign wr = acc & i_wb_we;
  assign o_wb_ack = ack_q;
  assign o_wb_dat = rd_q;

  function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] dat,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return res;
  endfunction

  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (i_wb_adr)
      ADDR_CTRL: rd_d[CTRL_W-1:0] = ctrl_q;
      ADDR_WDT_TIMEOUT: rd_d[15:0] = timeout_q;
      ADDR_STATUS: begin
        rd_d[STAT_TIMEOUT_BIT] = tripped;
        rd_d[STAT_RELAY_BIT] = relay_q;
        rd_d[STAT_LEAK_BIT] = leak_s;
        rd_d[STAT_OPEN_BIT] = open_s;
        rd_d[STAT_SILENCED_BIT] = silenced_q;
        rd_d[STAT_INIT_BIT] = init_mode_q;
      end
      ADDR_COMM_ACTIVE: rd_d[23:0] = active_q;
      ADDR_COMM_PENDING: rd_d[23:0] = pending_q;
      ADDR_IRQ_STATUS: rd_d[IRQ_W-1:0] = irq_stat_q;
      ADDR_IRQ_MASK: rd_d[IRQ_W-1:0] = irq_mask_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q <= 1'b0;
      rd_q <= 32'h0000_0000;
    end else if (i_clk_en) begin
      ack_q <= acc;
      if (acc && !i_wb_we) begin
        rd_q <= rd_d;
      end
    end
  end

  // Configuration writes; the host relay bit is frozen while the watchdog is tripped.
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q <= CTRL_RESET;
      timeout_q <= WDT_TIMEOUT_RESET;
      irq_mask_q <= IRQ_RESET;
    end else if (i_clk_en && wr) begin
      if (i_wb_adr == ADDR_CTRL && i_wb_sel[0]) begin
        ctrl_q[CTRL_WDT_EN_BIT] <= i_wb_dat[CTRL_WDT_EN_BIT];
        ctrl_q[CTRL_ALARM_EN_BIT] <= i_wb_dat[CTRL_ALARM_EN_BIT];
        ctrl_q[CTRL_SAFE_BIT] <= i_wb_dat[CTRL_SAFE_BIT];
        if (!tripped) begin
          ctrl_q[CTRL_RELAY_BIT] <= i_wb_dat[CTRL_RELAY_BIT];
        end
      end
      if (i_wb_adr == ADDR_WDT_TIMEOUT) begin
        timeout_q <= timeout_mrg[15:0];
      end
      if (i_wb_adr == ADDR_IRQ_MASK && i_wb_sel[0]) begin
        irq_mask_q <= i_wb_dat[IRQ_W-1:0];
      end
    end
  end

  assign keepalive = wr && i_wb_adr == ADDR_CMD && i_wb_sel[0] && i_wb_dat[CMD_KEEPALIVE_BIT];
  assign clear_cmd = wr && i_wb_adr == ADDR_CMD && i_wb_sel[0] && i_wb_dat[CMD_TO_CLEAR_BIT];
  assign timeout_mrg = merge_sel({16'h0000, timeout_q}, i_wb_dat, i_wb_sel);
  assign pend_mrg = merge_sel({8'h00, pending_q}, i_wb_dat, i_wb_sel);

  // Millisecond tick for the watchdog and the blink timer.
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tick_cnt_q <= 32'h0000_0000;
    end else if (i_clk_en) begin
      tick_cnt_q <= tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
    end
  end
  assign tick = tick_cnt_q == 32'(TICK_CYCLES_P - 1);

  // The elapsed count restarts on every keep-alive; a zero timeout trips at once.
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ms_cnt_q <= 16'h0000;
    end else if (i_clk_en) begin
      if (keepalive || wdt_q != WDT_ARMED) begin
        ms_cnt_q <= 16'h0000;
      end else if (tick && ms_cnt_q != 16'hFFFF) begin
        ms_cnt_q <= ms_cnt_q + 16'h0001;
      end
    end
  end
  assign expire = ms_cnt_q >= timeout_q && !keepalive;

  // A trip in the same cycle as a clear still trips, so the event is not lost.
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wdt_q <= WDT_IDLE;
    end else if (i_clk_en) begin
      unique case (wdt_q)
        WDT_IDLE: begin
          if (ctrl_q[CTRL_WDT_EN_BIT]) begin
            wdt_q <= WDT_ARMED;
          end
        end
        WDT_ARMED: begin
          if (!ctrl_q[CTRL_WDT_EN_BIT]) begin
            wdt_q <= WDT_IDLE;
          end else if (expire) begin
            wdt_q <= WDT_TRIPPED;
          end
        end
        WDT_TRIPPED: begin
          if (clear_cmd) begin
            wdt_q <= WDT_IDLE;
          end
        end
        default: wdt_q <= WDT_IDLE;
      endcase
    end
  end
  assign tripped = wdt_q == WDT_TRIPPED;

  // Relay: the leak alarm owns it when enabled, else the safe value while tripped.
  always_comb begin
    if (ctrl_q[CTRL_ALARM_EN_BIT]) begin
      relay_d = leak_s;
    end else if (tripped) begin
      relay_d = ctrl_q[CTRL_SAFE_BIT];
    end else begin
      relay_d = ctrl_q[CTRL_RELAY_BIT];
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      relay_q <= 1'b0;
    end else if (i_clk_en) begin
      relay_q <= relay_d;
    end
  end
  assign o_relay = relay_q;

  // Indication and audible alarm.
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      blink_cnt_q <= 16'h0000;
      blink_q <= 1'b0;
      alarm_led_q <= 1'b0;
      silenced_q <= 1'b0;
    end else if (i_clk_en) begin
      if (tick) begin
        if (blink_cnt_q == BLINK_HALF_TICKS - 16'h0001) begin
          blink_cnt_q <= 16'h0000;
          blink_q <= ~blink_q;
        end else begin
          blink_cnt_q <= blink_cnt_q + 16'h0001;
        end
      end
      alarm_led_q <= leak_s | (open_s & blink_q);
      // Silence lasts until the alarm goes away, so a new alarm sounds again.
      if (silence_s && !silence_prev_q) begin
        silenced_q <= 1'b1;
      end else if (!leak_s && !open_s) begin
        silenced_q <= 1'b0;
      end
    end
  end
  assign o_alarm_led = alarm_led_q;
  assign o_power_led = cfg_loaded_q;
  assign o_buzzer = (leak_s | open_s) & ~silenced_q;

  // Interrupts: sticky, write one to clear, a new event wins over the clear.
  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_stat_q <= IRQ_RESET;
    end else if (i_clk_en) begin
      irq_stat_q <= (irq_stat_q & ~((wr && i_wb_adr == ADDR_IRQ_STATUS && i_wb_sel[0])
          ? i_wb_dat[IRQ_W-1:0] : 3'h0))
          | {open_s & ~open_prev_q, leak_s & ~leak_prev_q, expire & (wdt_q == WDT_ARMED)
             & ctrl_q[CTRL_WDT_EN_BIT]};
    end
  end
  assign o_irq = |(irq_stat_q & irq_mask_q);

  // Power-up configuration from the switches, caught once after the pins settle.
  always_comb begin
    load_cfg = i_stored_valid ? i_stored_cfg : FACTORY_CFG;
    load_cfg.protocol = sw_s.protocol_select_switch ? PROTO_ASCII : PROTO_MODBUS;
    if (!sw_s.config_source_switch) begin
      load_cfg.address = HW_ADDR_BASE + (sw_s.address_bank_switch ? HW_ADDR_BANK_STEP : 8'h00)
          + {4'h0, addr_sel_s};
    end
    if (sw_s.init_mode_switch) begin
      load_cfg = INIT_CFG;
    end
  end

  // Field filter on a pending-configuration write; stored values apply at next power-up.
  always_comb begin
    merged_cfg = lmhw_comm_cfg_type'(pend_mrg[23:0]);
    wr_cfg = pending_q;
    wr_cfg.address = merged_cfg.address;
    wr_cfg.resp_delay = merged_cfg.resp_delay;
    if (init_mode_q) begin
      wr_cfg = merged_cfg;
    end else if (active_q.protocol == PROTO_MODBUS) begin
      wr_cfg.baud = merged_cfg.baud;
      wr_cfg.parity = merged_cfg.parity;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      settle_q <= 2'h0;
      cfg_loaded_q <= 1'b0;
      init_mode_q <= 1'b0;
      active_q <= FACTORY_CFG;
      pending_q <= FACTORY_CFG;
      save_q <= 1'b0;
    end else if (i_clk_en) begin
      save_q <= 1'b0;
      if (!cfg_loaded_q) begin
        if (settle_q == STRAP_SETTLE) begin
          cfg_loaded_q <= 1'b1;
          init_mode_q <= sw_s.init_mode_switch;
          active_q <= load_cfg;
          pending_q <= load_cfg;
        end else begin
          settle_q <= settle_q + 2'h1;
        end
      end else if (wr && i_wb_adr == ADDR_COMM_PENDING) begin
        pending_q <= wr_cfg;
        save_q <= 1'b1;
      end
    end
  end
  assign o_cfg_pending = pending_q;
  assign o_cfg_save = save_q;

  sequence s_trip_held;
    tripped && !clear_cmd;
  endsequence

  property p_alarm_relay;
    @(posedge i_sys_clk) disable iff (!rst_n_q)
      i_clk_en && ctrl_q[CTRL_ALARM_EN_BIT] |=> o_relay == $past(leak_s);
  endproperty
  a_alarm_relay: assert property (p_alarm_relay)
    else $error("relay not following alarm");

  property p_alarm_on;
    @(posedge i_sys_clk) disable iff (!rst_n_q)
      i_clk_en && ctrl_q[CTRL_ALARM_EN_BIT] && $rose(leak_s) |=> o_relay;
  endproperty
  a_alarm_on: assert property (p_alarm_on)
    else $error("relay not on for alarm");

  property p_safe_value;
    @(posedge i_sys_clk) disable iff (!rst_n_q)
      i_clk_en && tripped && !ctrl_q[CTRL_ALARM_EN_BIT]
      |=> o_relay == $past(ctrl_q[CTRL_SAFE_BIT]);
  endproperty
  a_safe_value: assert property (p_safe_value)
    else $error("relay not at safe value");

  property p_trip;
    @(posedge i_sys_clk) disable iff (!rst_n_q)
      i_clk_en && wdt_q == WDT_ARMED && ctrl_q[CTRL_WDT_EN_BIT] && expire |=> tripped;
  endproperty
  a_trip: assert property (p_trip)
    else $error("watchdog failed to trip");

  property p_trip_hold;
    @(posedge i_sys_clk) disable iff (!rst_n_q)
      i_clk_en and s_trip_held |=> tripped;
  endproperty
  a_trip_hold: assert property (p_trip_hold)
    else $error("timeout dropped without clear");

  property p_clear;
    @(posedge i_sys_clk) disable iff (!rst_n_q)
      i_clk_en && tripped && clear_cmd |=> !tripped;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear command ignored");

  property p_host_frozen;
    @(posedge i_sys_clk) disable iff (!rst_n_q)
      i_clk_en && tripped |=> ctrl_q[CTRL_RELAY_BIT] == $past(ctrl_q[CTRL_RELAY_BIT]);
  endproperty
  a_host_frozen: assert property (p_host_frozen)
    else $error("host relay changed while tripped");

  property p_silence;
    @(posedge i_sys_clk) disable iff (!rst_n_q)
      i_clk_en && silence_s && !silence_prev_q |=> !o_buzzer;
  endproperty
  a_silence: assert property (p_silence)
    else $error("buzzer still on after silence");

  property p_leak_led;
    @(posedge i_sys_clk) disable iff (!rst_n_q)
      i_clk_en && leak_s |=> o_alarm_led;
  endproperty
  a_leak_led: assert property (p_leak_led)
    else $error("alarm LED off during leak");

  property p_init_load;
    @(posedge i_sys_clk) disable iff (!rst_n_q)
      i_clk_en && !cfg_loaded_q && settle_q == STRAP_SETTLE && sw_s.init_mode_switch
      |=> active_q == INIT_CFG && init_mode_q;
  endproperty
  a_init_load: assert property (p_init_load)
    else $error("init mode settings not loaded");
endmodule

// ### design/lmhw_pkg.sv
// Constants, field layouts and types of the leak-module host watchdog and configuration block.
package lmhw_pkg;

  // Register byte offsets on the Wishbone slave.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_WDT_TIMEOUT = 8'h04;
  localparam logic [7:0] ADDR_CMD = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_COMM_ACTIVE = 8'h10;
  localparam logic [7:0] ADDR_COMM_PENDING = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;

  // Control register fields.
  localparam int CTRL_WDT_EN_BIT = 0;
  localparam int CTRL_ALARM_EN_BIT = 1;
  localparam int CTRL_RELAY_BIT = 2;
  localparam int CTRL_SAFE_BIT = 3;
  localparam int CTRL_W = 4;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // Command register fields, write-only strobes.
  localparam int CMD_KEEPALIVE_BIT = 0;
  localparam int CMD_TO_CLEAR_BIT = 1;

  // Status register fields.
  localparam int STAT_TIMEOUT_BIT = 0;
  localparam int STAT_RELAY_BIT = 1;
  localparam int STAT_LEAK_BIT = 2;
  localparam int STAT_OPEN_BIT = 3;
  localparam int STAT_SILENCED_BIT = 4;
  localparam int STAT_INIT_BIT = 5;

  // Interrupt status and mask fields.
  localparam int IRQ_TIMEOUT_BIT = 0;
  localparam int IRQ_LEAK_BIT = 1;
  localparam int IRQ_OPEN_BIT = 2;
  localparam int IRQ_W = 3;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // Watchdog timeout in milliseconds.
  localparam logic [15:0] WDT_TIMEOUT_RESET = 16'h03E8;

  // Timing.
  localparam int CLK_HZ = 250000000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int BLINK_HALF_MS = 250;
  localparam logic [15:0] BLINK_HALF_TICKS = 16'(BLINK_HALF_MS / TICK_MS);
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // Hardware-configured address window.
  localparam logic [7:0] HW_ADDR_BASE = 8'h60;
  localparam logic [7:0] HW_ADDR_BANK_STEP = 8'h10;

  typedef enum logic {
    PROTO_MODBUS = 1'b0,
    PROTO_ASCII = 1'b1
  } lmhw_proto_type;

  localparam logic [3:0] BAUD_9600 = 4'h3;
  localparam logic [1:0] PARITY_NONE = 2'h0;

  typedef struct packed {
    logic [7:0] resp_delay;
    logic checksum;
    logic [1:0] parity;
    logic [3:0] baud;
    logic [7:0] address;
    lmhw_proto_type protocol;
  } lmhw_comm_cfg_type;

  localparam lmhw_comm_cfg_type FACTORY_CFG = '{resp_delay: 8'h00, checksum: 1'b0,
      parity: PARITY_NONE, baud: BAUD_9600, address: 8'h01, protocol: PROTO_MODBUS};
  localparam lmhw_comm_cfg_type INIT_CFG = '{resp_delay: 8'h00, checksum: 1'b0,
      parity: PARITY_NONE, baud: BAUD_9600, address: 8'h00, protocol: PROTO_ASCII};

  typedef struct packed {
    logic init_mode_switch;
    logic address_bank_switch;
    logic config_source_switch;
    logic protocol_select_switch;
  } lmhw_switch_type;

  typedef enum logic [2:0] {
    WDT_IDLE = 3'b001,
    WDT_ARMED = 3'b010,
    WDT_TRIPPED = 3'b100
  } lmhw_wdt_state_type;

endpackage

// ### design/lmhw_sync.sv
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module lmhw_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // Data
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      o_sync <= '0;
    end else if (i_clk_en) begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

// ### test/lmhw_host_model.sv
// Host side model: a Wishbone classic master issuing configuration and keep-alive traffic.
`timescale 1ns/1ps
module lmhw_host_model (
  // Clock
  input wire logic i_sys_clk,
  // Wishbone master
  output logic o_wb_cyc,
  output logic o_wb_stb,
  output logic o_wb_we,
  output logic [7:0] o_wb_adr,
  output logic [3:0] o_wb_sel,
  output logic [31:0] o_wb_dat,
  input wire logic [31:0] i_wb_dat,
  input wire logic i_wb_ack
);
  import lmhw_pkg::*;
  // This host talks to a single module, so the module address is unique.
  initial begin
    o_wb_cyc = 1'b0;
    o_wb_stb = 1'b0;
    o_wb_we = 1'b0;
    o_wb_adr = 8'h00;
    o_wb_sel = 4'hF;
    o_wb_dat = 32'h00000000;
  end
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge i_sys_clk);
    o_wb_cyc <= 1'b1;
    o_wb_stb <= 1'b1;
    o_wb_we <= we;
    o_wb_sel <= 4'hF;
    o_wb_adr <= a;
    o_wb_dat <= d;
    do @(posedge i_sys_clk); while (i_wb_ack !== 1'b1);
    q = i_wb_dat;
    o_wb_cyc <= 1'b0;
    o_wb_stb <= 1'b0;
    // A released data bus must not keep showing the last value.
    o_wb_dat <= ~d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h00000000, q);
  endtask
  task automatic keep_alive();
    wr(ADDR_CMD, 32'(1 << CMD_KEEPALIVE_BIT));
  endtask
  task automatic clear_timeout();
    wr(ADDR_CMD, 32'(1 << CMD_TO_CLEAR_BIT));
  endtask
endmodule

// ### test/testbench.sv
// Self-checking testbench for the leak-module host watchdog and configuration block.
`timescale 1ns/1ps
module testbench;
  import lmhw_pkg::*;
  localparam int TICKS = 4;
  localparam int WD = 1 << CTRL_WDT_EN_BIT;
  localparam int AL = 1 << CTRL_ALARM_EN_BIT;
  localparam int RL = 1 << CTRL_RELAY_BIT;
  localparam int SF = 1 << CTRL_SAFE_BIT;
  logic clk, rst_n, en, sil, leak, open, cyc, stb, we, ack, save, relay, aled, pled, buz, irq;
  logic [7:0] adr;
  logic [3:0] sel, asel;
  logic [31:0] wdat, rdat;
  lmhw_switch_type sw;
  lmhw_comm_cfg_type pend;
  int mismatches = 0;
  int checked = 0;
  lmhw_host_model host (.i_sys_clk(clk), .o_wb_cyc(cyc), .o_wb_stb(stb), .o_wb_we(we),
    .o_wb_adr(adr), .o_wb_sel(sel), .o_wb_dat(wdat), .i_wb_dat(rdat), .i_wb_ack(ack));
  lmhw_top #(.TICK_CYCLES_P(TICKS)) dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_clk_en(en),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_switches(sw),
    .i_addr_select(asel), .i_silence_button(sil), .i_leak_detect(leak),
    .i_open_detect(open), .i_stored_cfg('0), .i_stored_valid(1'b0), .o_cfg_pending(pend),
    .o_cfg_save(save), .o_relay(relay), .o_alarm_led(aled), .o_power_led(pled),
    .o_buzzer(buz), .o_irq(irq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (mismatches == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input int b, input logic exp);
    logic [31:0] q;
    host.rd(a, q);
    chk(q[b], exp);
  endtask
  task automatic rdw(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    host.rd(a, q);
    chk(q, exp);
  endtask
  task automatic t_power();
    chk(pled, 1'b1);
    rdw(ADDR_COMM_ACTIVE, {8'h00, FACTORY_CFG});
    rdw(8'hFC, 32'h00000000);
  endtask
  task automatic t_wdt();
    host.wr(ADDR_WDT_TIMEOUT, 32'h00000004);
    rdw(ADDR_WDT_TIMEOUT, 32'h00000004);
    host.wr(ADDR_CTRL, WD | SF);
    cy(50);
    rdc(ADDR_STATUS, STAT_TIMEOUT_BIT, 1'b1);
    chk(relay, 1'b1);
    host.keep_alive();
    rdc(ADDR_STATUS, STAT_TIMEOUT_BIT, 1'b1);
    host.wr(ADDR_CTRL, RL);
    cy(3);
    chk(relay, 1'b0);
    host.clear_timeout();
    rdc(ADDR_STATUS, STAT_TIMEOUT_BIT, 1'b0);
    chk(relay, 1'b0);
    host.wr(ADDR_CTRL, RL);
    cy(3);
    chk(relay, 1'b1);
    rdc(ADDR_STATUS, STAT_RELAY_BIT, 1'b1);
    host.wr(ADDR_CTRL, 32'h00000000);
    rdc(ADDR_STATUS, STAT_RELAY_BIT, 1'b0);
  endtask
  task automatic t_alive();
    host.wr(ADDR_CTRL, WD);
    en <= 1'b0;
    cy(40);
    en <= 1'b1;
    repeat (15) host.keep_alive();
    rdc(ADDR_STATUS, STAT_TIMEOUT_BIT, 1'b0);
    host.wr(ADDR_CTRL, 32'h00000000);
  endtask
  task automatic t_leak();
    logic a;
    host.wr(ADDR_CTRL, WD | AL | SF);
    cy(50);
    rdc(ADDR_STATUS, STAT_TIMEOUT_BIT, 1'b1);
    chk(relay, 1'b0);
    leak <= 1'b1;
    cy(6);
    chk(relay, 1'b1);
    chk({aled, buz}, 2'h3);
    host.wr(ADDR_IRQ_MASK, 32'h00000007);
    a = irq;
    host.wr(ADDR_IRQ_MASK, 32'h00000000);
    chk(a ^ irq, 1'b1);
    host.wr(ADDR_IRQ_STATUS, 32'h00000007);
    rdw(ADDR_IRQ_STATUS, 32'h00000000);
    chk(irq, 1'b0);
    sil <= 1'b1;
    cy(5);
    sil <= 1'b0;
    cy(3);
    chk(buz, 1'b0);
    leak <= 1'b0;
    host.clear_timeout();
    host.wr(ADDR_CTRL, 32'h00000000);
  endtask
  task automatic t_blink();
    logic a;
    open <= 1'b1;
    cy(8);
    a = aled;
    cy(int'(BLINK_HALF_TICKS) * TICKS);
    chk({aled, buz}, {~a, 1'b1});
    open <= 1'b0;
  endtask
  task automatic t_pend(input logic init);
    lmhw_comm_cfg_type rq;
    lmhw_comm_cfg_type ex;
    rq = '{8'h05, 1'b1, 2'h1, 4'h5, 8'h22, PROTO_ASCII};
    ex = init ? rq : '{8'h05, 1'b0, 2'h1, 4'h5, 8'h22, PROTO_MODBUS};
    host.wr(ADDR_COMM_PENDING, {8'h00, rq});
    chk(save, 1'b1);
    cy(3);
    chk(pend, ex);
    rdw(ADDR_COMM_ACTIVE, {8'h00, init ? INIT_CFG : FACTORY_CFG});
  endtask
  task automatic t_boot(input logic [3:0] s);
    sw <= lmhw_switch_type'(s);
    rst_n <= 1'b0;
    cy(6);
    rst_n <= 1'b1;
    cy(20);
  endtask
  task automatic t_init();
    lmhw_comm_cfg_type ex;
    ex = FACTORY_CFG;
    ex.address = HW_ADDR_BASE + HW_ADDR_BANK_STEP + 8'h03;
    ex.protocol = PROTO_ASCII;
    t_boot(4'h5);
    rdw(ADDR_COMM_ACTIVE, {8'h00, ex});
    t_boot(4'hA);
    rdc(ADDR_STATUS, STAT_INIT_BIT, 1'b1);
    t_pend(1'b1);
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #40000;
    mismatches++;
    results();
  end
  initial begin
    {rst_n, sil, leak, open} = 4'h0;
    en = 1'b1;
    asel = 4'h3;
    sw = lmhw_switch_type'(4'h2);
    cy(6);
    rst_n <= 1'b1;
    cy(20);
    t_power();
    t_wdt();
    t_alive();
    t_leak();
    t_blink();
    t_pend(1'b0);
    t_init();
    results();
  end
endmodule
